// ---- logic/upc_pkg.sv ----
// Operation
// (RULE_01) Gate high passes words into I/Q paths
// (RULE_02) Gate low feeds zeros into paths
// (RULE_03) First word after gate is I, alternate
// (RULE_04) Outside single tone, pin is clock output
// (RULE_05) Single tone: pin strobe loads tuning word
// (RULE_06) Profile change applies tuning word immediately
// (RULE_07) Power-down halts logic, loop optionally kept
// (RULE_08) Hardware reset sets defined default state
// (RULE_09) Lock output follows loop lock live
// (RULE_10) Overflow output low unless filters overflow
// (RULE_11) Select pin picks differential or single reference
// (RULE_12) Source sends two's complement, top bit sign
// (RULE_13) Interpolating mode routes every word to I
// (RULE_14) Two select inputs choose one of four profiles
// (RULE_15) Source words valid at data clock rising edge
// (RULE_16) Strobe and profile inputs synchronised first
`default_nettype none
package upc_pkg;

  // ----------------------------------------------------------------
  // Register map (AXI4-Lite byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] UPC_ADDR_CTRL = 8'h00;    // Mode, keep-loop
  localparam logic [7:0] UPC_ADDR_STATUS = 8'h04;  // Live state
  localparam logic [7:0] UPC_ADDR_IRQ = 8'h08;     // Sticky events, write one to clear
  localparam logic [7:0] UPC_ADDR_MASK = 8'h0c;    // Event enables
  localparam logic [7:0] UPC_ADDR_ACTIVE = 8'h10;  // Word in accumulator
  localparam logic [7:0] UPC_ADDR_PROF0 = 8'h20;   // Profile words at 0x20..0x2c

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int UPC_CTRL_MODE_LSB = 0;      // Two mode bits
  localparam int UPC_CTRL_KEEP_LOOP = 2;     // Loop kept in power-down
  localparam int UPC_EV_OVFL = 0;            // Filter overflow event
  localparam int UPC_EV_UNLOCK = 1;          // Loop lost lock event
  localparam int UPC_EV_LOAD = 2;            // Tuning word loaded event
  localparam int UPC_NUM_EV = 3;
  localparam logic [31:0] UPC_PROF_RESET = 32'h00000000;
  localparam logic [3:0] UPC_DIV_HALF = 4'h1;  // Data clock half period in cycles

  // Operating modes
  typedef enum logic [1:0] {
    UPC_MODE_QUAD = 2'b00,
    UPC_MODE_TONE = 2'b01,
    UPC_MODE_INTERP = 2'b10
  } upc_mode_e;

  // One demultiplexed sample pair
  typedef struct packed {
    logic [13:0] i_word;
    logic [13:0] q_word;
  } upc_iq_s;

endpackage
`default_nettype wire

// ---- logic/upc_top.sv ----
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module upc_top
  import upc_pkg::*;
#(
  parameter int WORD_W = 14
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic hw_reset,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Baseband port
  input wire logic [WORD_W-1:0] baseband_word_bus,
  input wire logic transmit_gate,
  input wire logic data_clock_or_update_pin_in,
  output logic data_clock_or_update_pin_out,
  output logic data_clock_or_update_pin_oe,
  input wire logic profile_sel_hi,
  input wire logic profile_sel_lo,
  input wire logic logic_power_down,
  input wire logic diff_ref_select,
  input wire logic loop_locked_raw,
  input wire logic filter_overflow_raw,
  // Outputs toward the data path and pins
  output logic [WORD_W-1:0] i_path,
  output logic [WORD_W-1:0] q_path,
  output logic iq_valid,
  output logic [31:0] tuning_word,
  output logic ref_diff_mode,
  output logic loop_run,
  output logic loop_lock,
  output logic interp_filter_overflow,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic [7:0] awaddr;           // Captured write address
    logic aw_got;
    logic [31:0] wdata;           // Captured write data
    logic [3:0] wstrb;
    logic w_got;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [1:0] mode;
    logic keep_loop;
    logic [UPC_NUM_EV-1:0] events;
    logic [UPC_NUM_EV-1:0] mask;
    logic [3:0][31:0] prof;       // Four profile words
    logic [31:0] active;          // Accumulator word
    logic [1:0] ps_s1;            // Profile select first stage
    logic [1:0] ps_s2;
    logic [1:0] ps_prev;
    logic upd_s1;                 // Strobe first stage
    logic upd_s2;
    logic upd_prev;
    logic [3:0] div;              // Data clock divider
    logic pclk;
    logic gate_d;                 // Gate seen in previous word slot
    logic q_next;                 // Next word goes to Q
    logic [WORD_W-1:0] i_w;
    logic [WORD_W-1:0] q_w;
    logic iq_v;
    logic lock;
    logic lock_d;
    logic ovfl;
    logic diff;
    logic run;
    logic irq;
    logic oe;                     // Pin driven as data clock
  } upc_state_s;

  upc_state_s r;       // Registered state
  upc_state_s next_r;  // Next state

  // Write strobe byte merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        merge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction

  // Profile slot hit for an address, index in low bits
  function automatic logic prof_hit(input logic [7:0] a);
    prof_hit = (a[7:4] == UPC_ADDR_PROF0[7:4]) && (a[1:0] == 2'b00);
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] ps;
    logic wr_go;
    logic pclk_rise;
    logic [UPC_NUM_EV-1:0] set_ev;
    logic [UPC_NUM_EV-1:0] clr_ev;
    ps = 2'b00;
    wr_go = 1'b0;
    pclk_rise = 1'b0;
    set_ev = '0;
    clr_ev = '0;
    next_r = r;

    // Synchronisers for profile and strobe inputs
    next_r.ps_s1 = {profile_sel_hi, profile_sel_lo};  // RULE_16
    next_r.ps_s2 = r.ps_s1;
    // Pin counts as a strobe only in tone mode, so the data clock cannot fake an edge on entry
    next_r.upd_s1 = data_clock_or_update_pin_in && (r.mode == UPC_MODE_TONE);  // RULE_16
    next_r.upd_s2 = r.upd_s1;
    next_r.upd_prev = r.upd_s2;
    next_r.ps_prev = r.ps_s2;
    ps = r.ps_s2;                                     // RULE_14

    // Status pins follow their sources live
    next_r.lock = loop_locked_raw;                    // RULE_09
    next_r.lock_d = r.lock;
    next_r.ovfl = filter_overflow_raw;                // RULE_10
    next_r.diff = diff_ref_select;                    // RULE_11
    next_r.run = !logic_power_down || r.keep_loop;    // RULE_07

    // Write address and data taken in either order
    if (s_axi_awvalid && r.awready) begin
      next_r.awaddr = s_axi_awaddr;
      next_r.aw_got = 1'b1;
      next_r.awready = 1'b0;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
      next_r.w_got = 1'b1;
      next_r.wready = 1'b0;
    end
    wr_go = r.aw_got && r.w_got && !r.bvalid;
    if (wr_go) begin
      next_r.bvalid = 1'b1;
      next_r.bresp = 2'b00;
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      if (r.awaddr == UPC_ADDR_CTRL) begin
        next_r.mode = r.wstrb[0] ? r.wdata[UPC_CTRL_MODE_LSB +: 2] : r.mode;
        next_r.keep_loop = r.wstrb[0] ? r.wdata[UPC_CTRL_KEEP_LOOP] : r.keep_loop;
      end else if (r.awaddr == UPC_ADDR_IRQ) begin
        clr_ev = r.wstrb[0] ? r.wdata[UPC_NUM_EV-1:0] : '0;
      end else if (r.awaddr == UPC_ADDR_MASK) begin
        next_r.mask = r.wstrb[0] ? r.wdata[UPC_NUM_EV-1:0] : r.mask;
      end else if (prof_hit(r.awaddr)) begin
        next_r.prof[r.awaddr[3:2]] = merge(r.prof[r.awaddr[3:2]], r.wdata, r.wstrb);
      end else if (r.awaddr != UPC_ADDR_STATUS && r.awaddr != UPC_ADDR_ACTIVE) begin
        next_r.bresp = 2'b10;  // Unmapped: slave error
      end
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready = 1'b1;
    end

    // Read channel
    if (s_axi_arvalid && r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rresp = 2'b00;
      next_r.rdata = 32'h00000000;
      if (s_axi_araddr == UPC_ADDR_CTRL) begin
        next_r.rdata[2:0] = {r.keep_loop, r.mode};
      end else if (s_axi_araddr == UPC_ADDR_STATUS) begin
        next_r.rdata[5:0] = {r.ps_s2, r.diff, r.run, r.ovfl, r.lock};
      end else if (s_axi_araddr == UPC_ADDR_IRQ) begin
        next_r.rdata[UPC_NUM_EV-1:0] = r.events;
      end else if (s_axi_araddr == UPC_ADDR_MASK) begin
        next_r.rdata[UPC_NUM_EV-1:0] = r.mask;
      end else if (s_axi_araddr == UPC_ADDR_ACTIVE) begin
        next_r.rdata = r.active;
      end else if (prof_hit(s_axi_araddr)) begin
        next_r.rdata = r.prof[s_axi_araddr[3:2]];
      end else begin
        next_r.rresp = 2'b10;
      end
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end

    // Pin direction follows the mode held in the next state
    next_r.oe = (next_r.mode != UPC_MODE_TONE);       // RULE_04 RULE_05

    // Tuning word activation
    if (r.ps_s2 != r.ps_prev) begin
      next_r.active = r.prof[ps];                     // RULE_06
      set_ev[UPC_EV_LOAD] = 1'b1;
    end else if (r.mode == UPC_MODE_TONE && r.upd_s2 && !r.upd_prev) begin
      next_r.active = r.prof[ps];                     // RULE_05
      set_ev[UPC_EV_LOAD] = 1'b1;
    end

    // Data clock and word steering, halted in power-down
    next_r.iq_v = 1'b0;
    if (logic_power_down || r.mode == UPC_MODE_TONE) begin
      next_r.div = 4'h0;                              // RULE_07
      next_r.pclk = 1'b0;
      next_r.q_next = 1'b0;
    end else begin
      if (r.div == UPC_DIV_HALF - 4'h1) begin
        next_r.div = 4'h0;
        next_r.pclk = !r.pclk;                        // RULE_04
        pclk_rise = !r.pclk;
      end else begin
        next_r.div = r.div + 4'h1;
      end
      if (pclk_rise) begin
        next_r.gate_d = transmit_gate;
        if (!transmit_gate) begin
          next_r.i_w = '0;                            // RULE_02
          next_r.q_w = '0;
          next_r.q_next = 1'b0;
          next_r.iq_v = 1'b1;
        end else if (r.mode == UPC_MODE_INTERP) begin
          next_r.i_w = baseband_word_bus;             // RULE_13
          next_r.q_w = '0;
          next_r.iq_v = 1'b1;
        end else if (!r.gate_d || !r.q_next) begin
          next_r.i_w = baseband_word_bus;             // RULE_01 RULE_03
          next_r.q_next = 1'b1;
        end else begin
          next_r.q_w = baseband_word_bus;             // RULE_03
          next_r.q_next = 1'b0;
          next_r.iq_v = 1'b1;
        end
      end
    end

    // Sticky events: set wins over clear
    set_ev[UPC_EV_OVFL] = r.ovfl;
    set_ev[UPC_EV_UNLOCK] = r.lock_d && !r.lock;
    next_r.events = (r.events & ~clr_ev) | set_ev;
    next_r.irq = |(r.events & r.mask);
  end

  // ----------------------------------------------------------------
  // State register, reset by either reset input
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
      r.oe <= 1'b1;
      r.prof <= {4{UPC_PROF_RESET}};
    end else if (hw_reset) begin
      r <= '0;                                        // RULE_08
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
      r.oe <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from state
  // ----------------------------------------------------------------
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = r.rdata;
  assign data_clock_or_update_pin_out = r.pclk;
  assign data_clock_or_update_pin_oe = r.oe;
  assign i_path = r.i_w;
  assign q_path = r.q_w;
  assign iq_valid = r.iq_v;
  assign tuning_word = r.active;
  assign ref_diff_mode = r.diff;
  assign loop_run = r.run;
  assign loop_lock = r.lock;
  assign interp_filter_overflow = r.ovfl;
  assign irq = r.irq;

endmodule
`default_nettype wire

// ---- testbench/upc_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checks of the converter front end
// ----------------------------------------
module upc_properties #(
  parameter int WORD_W = 14
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic hw_reset,
  input wire logic transmit_gate,
  input wire logic logic_power_down,
  input wire logic diff_ref_select,
  input wire logic loop_locked_raw,
  input wire logic filter_overflow_raw,
  input wire logic data_clock_or_update_pin_out,
  input wire logic data_clock_or_update_pin_oe,
  input wire logic [WORD_W-1:0] i_path,
  input wire logic [WORD_W-1:0] q_path,
  input wire logic iq_valid,
  input wire logic [31:0] tuning_word,
  input wire logic ref_diff_mode,
  input wire logic loop_lock,
  input wire logic interp_filter_overflow
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (!resetn);
  zero_fill_a: assert property ((!transmit_gate)[*4] ##0 iq_valid
    |-> i_path == '0 && q_path == '0) else $error("word passed while gate low");
  pair_pulse_a: assert property (iq_valid |=> !iq_valid)
    else $error("issue strobe held");
  data_clock_a: assert property ((data_clock_or_update_pin_oe && !logic_power_down && !hw_reset)[*4]
    |-> data_clock_or_update_pin_out != $past(data_clock_or_update_pin_out)) else $error("data clock stalled");
  halt_a: assert property (logic_power_down[*5]
    |-> !iq_valid && $stable(data_clock_or_update_pin_out)) else $error("activity in power-down");
  lock_live_a: assert property ($changed(loop_locked_raw) && !hw_reset
    |=> loop_lock == $past(loop_locked_raw)) else $error("lock output lags");
  ovfl_quiet_a: assert property ((!filter_overflow_raw)[*2]
    |-> !interp_filter_overflow) else $error("overflow without cause");
  ref_mode_a: assert property ($changed(diff_ref_select) && !hw_reset
    |=> ref_diff_mode == $past(diff_ref_select)) else $error("reference mode wrong");
  hw_reset_a: assert property (hw_reset
    |=> !iq_valid && tuning_word == '0 && !loop_lock) else $error("state kept over reset");
  cover property (iq_valid && transmit_gate);
  cover property ($changed(tuning_word));
  cover property (logic_power_down[*5]);
endmodule
`default_nettype wire

// ---- testbench/upc_source.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Baseband source on the word bus
// ----------------------------------------
module upc_source (
  input wire logic clock,
  input wire logic resetn,
  input wire logic pin_clk,
  input wire logic pin_oe,
  output logic [13:0] word,
  output logic gate,
  output logic pin_drive
);
  logic [13:0] fifo[$]; // Words waiting, two's complement
  logic strobe = 1'b0; // Update strobe level
  // New word after each data clock rise; inverted junk when idle
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      word <= 14'h0;
      gate <= 1'b0;
    end else if (pin_oe && pin_clk) begin
      if (fifo.size() > 0) begin
        word <= fifo.pop_front();
        gate <= 1'b1;
      end else begin
        word <= ~word;
        gate <= 1'b0;
      end
    end
  end
  assign pin_drive = strobe;
  // One update pulse of four cycles
  task automatic update;
    strobe <= 1'b1;
    repeat (4) @(posedge clock);
    strobe <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- testbench/test_upconverter_input_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_upconverter_input_control;
  import upc_pkg::*;
  logic clock = 1'b0, resetn = 1'b0, hw_reset = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, tuning_word, rv;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [13:0] baseband_word_bus, i_path, q_path;
  logic transmit_gate, data_clock_or_update_pin_in, data_clock_or_update_pin_out, data_clock_or_update_pin_oe;
  logic iq_valid, irq, pin_drive, ref_diff_mode, loop_run, loop_lock, interp_filter_overflow;
  logic profile_sel_hi = 1'b0, profile_sel_lo = 1'b0, logic_power_down = 1'b0;
  logic diff_ref_select = 1'b0, loop_locked_raw = 1'b0, filter_overflow_raw = 1'b0;
  logic [27:0] seen[$]; // Nonzero pairs issued
  int n_fail = 0, cmp_count = 0, cycles = 0;
  upc_top i_upc_top (
    .clock(clock), .resetn(resetn), .hw_reset(hw_reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .baseband_word_bus(baseband_word_bus), .transmit_gate(transmit_gate),
    .data_clock_or_update_pin_in(data_clock_or_update_pin_in),
    .data_clock_or_update_pin_out(data_clock_or_update_pin_out),
    .data_clock_or_update_pin_oe(data_clock_or_update_pin_oe),
    .profile_sel_hi(profile_sel_hi), .profile_sel_lo(profile_sel_lo), .logic_power_down(logic_power_down),
    .diff_ref_select(diff_ref_select), .loop_locked_raw(loop_locked_raw), .filter_overflow_raw(filter_overflow_raw),
    .i_path(i_path), .q_path(q_path), .iq_valid(iq_valid), .tuning_word(tuning_word),
    .ref_diff_mode(ref_diff_mode), .loop_run(loop_run), .loop_lock(loop_lock),
    .interp_filter_overflow(interp_filter_overflow), .irq(irq)
  );
  upc_source i_upc_source (.clock(clock), .resetn(resetn), .pin_clk(data_clock_or_update_pin_out),
    .pin_oe(data_clock_or_update_pin_oe), .word(baseband_word_bus), .gate(transmit_gate), .pin_drive(pin_drive));
  // Pin level: device clock when enabled, else the source strobe
  assign data_clock_or_update_pin_in = data_clock_or_update_pin_oe ? data_clock_or_update_pin_out : pin_drive;
  always #50 clock = ~clock;
  // Pair monitor and hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (iq_valid && {i_path, q_path} != 28'h0) seen.push_back({i_path, q_path});
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Profiles, unmapped read, select decode
  task automatic t_prof;
    rd(UPC_ADDR_CTRL);
    check(rv, 32'h0);
    rd(8'h40);
    check({30'h0, rr}, 32'h2);
    wr(8'h40, 32'h1);
    check({30'h0, br}, 32'h2);
    for (int k = 0; k < 4; k++) wr(UPC_ADDR_PROF0 + 8'(4 * k), 32'h5a5a0001 + k);
    check({30'h0, br}, 32'h0);
    for (int k = 3; k >= 0; k--) begin
      profile_sel_hi <= k[1];
      profile_sel_lo <= k[0];
      repeat (6) @(posedge clock);
      check(tuning_word, 32'h5a5a0001 + k);
    end
    $display("profile test done");
  endtask
  // Back-to-back words, negative among them
  task automatic t_quad;
    logic [13:0] w[4] = '{14'h0123, 14'h2001, 14'h3fff, 14'h1abc};
    seen.delete();
    foreach (w[k]) i_upc_source.fifo.push_back(w[k]);
    repeat (30) @(posedge clock);
    check(seen.size(), 2);
    check(seen[0], {w[0], w[1]});
    check(seen[1], {w[2], w[3]});
    $display("quadrature test done");
  endtask
  // Every word to the I path
  task automatic t_interp;
    logic [13:0] w[3] = '{14'h0005, 14'h2abc, 14'h1555};
    wr(UPC_ADDR_CTRL, 32'h2);
    seen.delete();
    foreach (w[k]) i_upc_source.fifo.push_back(w[k]);
    repeat (30) @(posedge clock);
    check(seen.size(), 3);
    foreach (w[k]) check(seen[k][27:14], w[k]);
    wr(UPC_ADDR_CTRL, 32'h0);
    $display("interpolating test done");
  endtask
  // Strobed load in tone mode, load interrupt
  task automatic t_tone;
    wr(UPC_ADDR_IRQ, 32'h7);
    wr(UPC_ADDR_MASK, 32'h4);
    wr(UPC_ADDR_CTRL, 32'h1);
    check(data_clock_or_update_pin_oe, 1'b0);
    check(irq, 1'b0);
    wr(UPC_ADDR_PROF0, 32'hc0de0001);
    repeat (6) @(posedge clock);
    check(tuning_word, 32'h5a5a0001);
    i_upc_source.update();
    repeat (6) @(posedge clock);
    check(tuning_word, 32'hc0de0001);
    rd(UPC_ADDR_ACTIVE);
    check(rv, 32'hc0de0001);
    check(irq, 1'b1);
    wr(UPC_ADDR_IRQ, 32'h4);
    check(irq, 1'b0);
    wr(UPC_ADDR_CTRL, 32'h0);
    $display("tone test done");
  endtask
  // Power-down with and without the loop kept
  task automatic t_pd;
    wr(UPC_ADDR_CTRL, 32'h4);
    logic_power_down <= 1'b1;
    repeat (8) @(posedge clock);
    check(loop_run, 1'b1);
    wr(UPC_ADDR_CTRL, 32'h0);
    check(loop_run, 1'b0);
    logic_power_down <= 1'b0;
    repeat (4) @(posedge clock);
    check(loop_run, 1'b1);
    $display("power-down test done");
  endtask
  // Live status pins and their events
  task automatic t_status;
    {diff_ref_select, loop_locked_raw, filter_overflow_raw} <= 3'h7;
    repeat (2) @(posedge clock);
    check({ref_diff_mode, loop_lock, interp_filter_overflow}, 3'h7);
    rd(UPC_ADDR_STATUS);
    check(rv, 32'hf);
    {diff_ref_select, loop_locked_raw, filter_overflow_raw} <= 3'h0;
    repeat (2) @(posedge clock);
    check({ref_diff_mode, loop_lock, interp_filter_overflow}, 3'h0);
    rd(UPC_ADDR_IRQ);
    check(rv, 32'h3);
    $display("status test done");
  endtask
  // Hardware reset mid-run
  task automatic t_reset;
    wr(UPC_ADDR_MASK, 32'h3);
    hw_reset <= 1'b1;
    @(posedge clock);
    hw_reset <= 1'b0;
    @(posedge clock);
    check(tuning_word, 32'h0);
    rd(UPC_ADDR_MASK);
    check(rv, 32'h0);
    $display("reset test done");
  endtask
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_prof();
    t_quad();
    t_interp();
    t_tone();
    t_pd();
    t_status();
    t_reset();
    conclude();
  end
endmodule
bind upc_top upc_properties #(.WORD_W(WORD_W)) i_upc_properties (
  .clock(clock), .resetn(resetn), .hw_reset(hw_reset),
  .transmit_gate(transmit_gate), .logic_power_down(logic_power_down), .diff_ref_select(diff_ref_select),
  .loop_locked_raw(loop_locked_raw), .filter_overflow_raw(filter_overflow_raw),
  .data_clock_or_update_pin_out(data_clock_or_update_pin_out),
  .data_clock_or_update_pin_oe(data_clock_or_update_pin_oe),
  .i_path(i_path), .q_path(q_path), .iq_valid(iq_valid), .tuning_word(tuning_word),
  .ref_diff_mode(ref_diff_mode), .loop_lock(loop_lock), .interp_filter_overflow(interp_filter_overflow)
);
`default_nettype wire
